/* File: src/erd_dev.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
// Operation
// - Gate bit errors all accesses but its own
// - One descriptor consumed per frame fragment
// - Ring base is software-aligned to four bytes
// - Count register holds entries minus one
// - Status base is software-aligned to eight bytes
// - No base or count writes while enabled
// - Both indices wrap to zero after count
// - Hardware produce index, software consume index
// - Equal indices mean the ring is empty
// - Produce one behind consume means ring full
// - Descriptor: pointer at 0, control at 4
// - Status: flags at 0, hash at 4
// - Fragment data may start at any byte
// - Never write past size field plus one
// - Completion event only after status committed
// - Hash word: source 8:0, destination 24:16
// - Hash captured once, reused for all fragments
// - Flags bits 10:0 hold written length minus one
// - Bit 29 set when frame outruns last descriptor
module erd_dev #(
  parameter int IDX_W = 16
) (
  input  wire logic                          I_CLK,
  input  wire logic                          I_RST,
  erd_if.dev                                 LINK,
  input  wire logic                          I_RX_VALID,
  input  wire logic [7:0]                    I_RX_DATA,
  input  wire logic                          I_RX_LAST,
  output logic                               O_RX_READY,
  input  wire logic                          I_HASH_VALID,
  input  wire logic [erd_pkg::ERD_HASH_W-1:0] I_SRC_HASH,
  input  wire logic [erd_pkg::ERD_HASH_W-1:0] I_DST_HASH,
  output logic                               O_RX_COMPLETE_EVENT,
  output logic                               O_OVERRUN,
  output logic                               O_RING_EMPTY,
  output logic                               O_RING_FULL
);
  import erd_pkg::*;

  logic             gate_reg, enable_reg;
  logic [31:0]      ring_base_reg, status_base_reg;
  logic [IDX_W-1:0] count_reg, hw_reg, sw_reg;
  logic             ack_reg, err_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rd_val;
  logic             mapped, access_ok, wr_ok;
  erd_state_t       state_reg;
  logic [31:0]      ptr_reg, hash_reg;
  logic [ERD_LEN_W-1:0] size_reg;
  logic [ERD_LEN_W:0]   cnt_reg;
  logic             irq_reg, nodesc_reg, last_reg, event_reg, overrun_reg;
  logic             mreq_we_reg;
  logic [31:0]      maddr_reg, mwdata_reg;
  logic [3:0]       mbe_reg;
  logic             full, empty, buf_full, next_full, mem_done;
  logic [IDX_W-1:0] hw_inc;

  function automatic logic [IDX_W-1:0] idx_inc(input logic [IDX_W-1:0] i,
                                               input logic [IDX_W-1:0] c);
    return (i == c) ? '0 : IDX_W'(i + 1'b1);
  endfunction

  function automatic logic [31:0] slot_addr(input logic [31:0] base,
                                            input logic [IDX_W-1:0] idx,
                                            input logic [31:0] off);
    return base + (32'(idx) << ERD_SLOT_SHIFT) + off;
  endfunction

  function automatic logic [31:0] flags_word(input logic [ERD_LEN_W:0] cnt,
                                             input logic nd);
    logic [31:0] w;
    w = '0;
    w[ERD_LEN_W-1:0] = ERD_LEN_W'(cnt - 1'b1);
    w[ERD_NODESC_BIT] = nd;
    return w;
  endfunction

  // Ring occupancy
  assign hw_inc    = idx_inc(hw_reg, count_reg);
  assign empty     = (hw_reg == sw_reg);
  assign full      = (hw_inc == sw_reg);
  assign next_full = (idx_inc(hw_inc, count_reg) == sw_reg);
  assign buf_full  = (cnt_reg == {1'b0, size_reg} + 1'b1);
  assign mem_done  = LINK.mem_ack;

  // Register read decode
  always_comb begin
    mapped = 1'b1;
    rd_val = '0;
    case (LINK.reg_addr)
      ERD_GATE_ADDR:   rd_val[ERD_GATE_BIT] = gate_reg;
      ERD_RING_ADDR:   rd_val = ring_base_reg;
      ERD_STBASE_ADDR: rd_val = status_base_reg;
      ERD_COUNT_ADDR:  rd_val = 32'(count_reg);
      ERD_HWIDX_ADDR:  rd_val = 32'(hw_reg);
      ERD_SWIDX_ADDR:  rd_val = 32'(sw_reg);
      ERD_CTRL_ADDR:   rd_val[ERD_EN_BIT] = enable_reg;
      ERD_STAT_ADDR: begin
        rd_val[ERD_EMPTY_BIT] = empty;
        rd_val[ERD_FULL_BIT]  = full;
      end
      default:         mapped = 1'b0;
    endcase
  end

  // Gate blocks everything except its own address
  assign access_ok = mapped & (~gate_reg | (LINK.reg_addr == ERD_GATE_ADDR));
  assign wr_ok     = LINK.reg_req & ~ack_reg & LINK.reg_we & access_ok;

  // Slave answer one cycle after the request
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= LINK.reg_req & ~ack_reg;
      err_reg <= LINK.reg_req & ~ack_reg & ~access_ok;
      if (LINK.reg_req & ~ack_reg) begin
        rdata_reg <= (access_ok & ~LINK.reg_we) ? rd_val : '0;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      gate_reg        <= 1'b0;
      enable_reg      <= 1'b0;
      ring_base_reg   <= '0;
      status_base_reg <= '0;
      count_reg       <= '0;
      sw_reg          <= '0;
    end else if (wr_ok) begin
      case (LINK.reg_addr)
        ERD_GATE_ADDR:   gate_reg <= LINK.reg_wdata[ERD_GATE_BIT];
        ERD_RING_ADDR:   ring_base_reg <= LINK.reg_wdata;
        ERD_STBASE_ADDR: status_base_reg <= LINK.reg_wdata;
        ERD_COUNT_ADDR:  count_reg <= LINK.reg_wdata[IDX_W-1:0];
        ERD_SWIDX_ADDR:  sw_reg <= LINK.reg_wdata[IDX_W-1:0];
        ERD_CTRL_ADDR:   enable_reg <= LINK.reg_wdata[ERD_EN_BIT];
        default:         gate_reg <= gate_reg;
      endcase
    end
  end

  // Produce index moves only once both status words are in memory
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      hw_reg <= '0;
    end else if (state_reg == ERD_ADVANCE) begin
      hw_reg <= hw_inc;
    end
  end

  // Address hash held for the whole frame
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      hash_reg <= '0;
    end else if (I_HASH_VALID) begin
      hash_reg <= (32'(I_SRC_HASH) << ERD_SRC_LSB)
                | (32'(I_DST_HASH) << ERD_DST_LSB);
    end
  end

  // Receive DMA sequencer
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_reg   <= ERD_IDLE;
      ptr_reg     <= '0;
      size_reg    <= '0;
      cnt_reg     <= '0;
      irq_reg     <= 1'b0;
      nodesc_reg  <= 1'b0;
      last_reg    <= 1'b0;
      event_reg   <= 1'b0;
      overrun_reg <= 1'b0;
      mreq_we_reg <= 1'b0;
      maddr_reg   <= '0;
      mwdata_reg  <= '0;
      mbe_reg     <= '0;
    end else begin
      event_reg   <= 1'b0;
      overrun_reg <= 1'b0;
      unique case (state_reg)
        ERD_IDLE: begin
          if (enable_reg & I_RX_VALID) begin
            if (full) begin
              overrun_reg <= 1'b1;
              state_reg   <= ERD_DROP;
            end else begin
              maddr_reg   <= slot_addr(ring_base_reg, hw_reg, ERD_PTR_OFF);
              mreq_we_reg <= 1'b0;
              state_reg   <= ERD_RD_PTR;
            end
          end
        end
        ERD_RD_PTR: begin
          if (mem_done) begin
            ptr_reg   <= LINK.mem_rdata;
            maddr_reg <= slot_addr(ring_base_reg, hw_reg, ERD_CTL_OFF);
            state_reg <= ERD_RD_CTL;
          end
        end
        ERD_RD_CTL: begin
          if (mem_done) begin
            size_reg   <= LINK.mem_rdata[ERD_LEN_W-1:0];
            irq_reg    <= LINK.mem_rdata[ERD_IRQ_BIT];
            cnt_reg    <= '0;
            nodesc_reg <= 1'b0;
            state_reg  <= ERD_DATA;
          end
        end
        ERD_DATA: begin
          if (I_RX_VALID & ~buf_full) begin
            maddr_reg   <= {ptr_reg[31:2], 2'b00};
            mbe_reg     <= ERD_BE_BYTE << ptr_reg[1:0];
            mwdata_reg  <= {4{I_RX_DATA}};
            mreq_we_reg <= 1'b1;
            last_reg    <= I_RX_LAST;
            ptr_reg     <= ptr_reg + 32'h1;
            cnt_reg     <= cnt_reg + 1'b1;
            state_reg   <= ERD_WR_BYTE;
          end
        end
        ERD_WR_BYTE: begin
          if (mem_done) begin
            if (last_reg | buf_full) begin
              // Close this fragment; later bytes go to the next descriptor, or are dropped when the ring has none left
              nodesc_reg <= ~last_reg & next_full;
              maddr_reg  <= slot_addr(status_base_reg, hw_reg, ERD_FLAGS_OFF);
              mwdata_reg <= flags_word(cnt_reg, ~last_reg & next_full);
              mbe_reg    <= ERD_BE_WORD;
              state_reg  <= ERD_WR_FLAGS;
            end else begin
              state_reg <= ERD_DATA;
            end
          end
        end
        ERD_WR_FLAGS: begin
          if (mem_done) begin
            maddr_reg  <= slot_addr(status_base_reg, hw_reg, ERD_HASH_OFF);
            mwdata_reg <= hash_reg;
            state_reg  <= ERD_WR_HASH;
          end
        end
        ERD_WR_HASH: begin
          if (mem_done) begin
            event_reg <= irq_reg;
            state_reg <= ERD_ADVANCE;
          end
        end
        ERD_ADVANCE: begin
          if (last_reg) begin
            state_reg <= ERD_IDLE;
          end else if (nodesc_reg) begin
            state_reg <= ERD_DROP;
          end else begin
            maddr_reg   <= slot_addr(ring_base_reg, hw_inc, ERD_PTR_OFF);
            mreq_we_reg <= 1'b0;
            state_reg   <= ERD_RD_PTR;
          end
        end
        ERD_DROP: begin
          if (I_RX_VALID & I_RX_LAST) begin
            state_reg <= ERD_IDLE;
          end
        end
      endcase
    end
  end

  // Memory master and user-side outputs
  assign LINK.mem_req   = (state_reg == ERD_RD_PTR) | (state_reg == ERD_RD_CTL)
                        | (state_reg == ERD_WR_BYTE) | (state_reg == ERD_WR_FLAGS)
                        | (state_reg == ERD_WR_HASH);
  assign LINK.mem_we    = mreq_we_reg;
  assign LINK.mem_addr  = maddr_reg;
  assign LINK.mem_wdata = mwdata_reg;
  assign LINK.mem_be    = mbe_reg;
  assign LINK.reg_ack   = ack_reg;
  assign LINK.reg_err   = err_reg;
  assign LINK.reg_rdata = rdata_reg;

  assign O_RX_READY          = ((state_reg == ERD_DATA) & ~buf_full) | (state_reg == ERD_DROP);
  assign O_RX_COMPLETE_EVENT = event_reg;
  assign O_OVERRUN           = overrun_reg;
  assign O_RING_EMPTY        = empty;
  assign O_RING_FULL         = full;
endmodule

/* File: include/erd_pkg.sv */
package erd_pkg;
  // Device register map, byte addresses on the device's slave port
  localparam logic [31:0] ERD_GATE_ADDR   = 32'hffe00ff4;
  localparam logic [31:0] ERD_RING_ADDR   = 32'hffe00100;
  localparam logic [31:0] ERD_STBASE_ADDR = 32'hffe00104;
  localparam logic [31:0] ERD_COUNT_ADDR  = 32'hffe00108;
  localparam logic [31:0] ERD_HWIDX_ADDR  = 32'hffe0010c;
  localparam logic [31:0] ERD_SWIDX_ADDR  = 32'hffe00110;
  localparam logic [31:0] ERD_CTRL_ADDR   = 32'hffe00114;
  localparam logic [31:0] ERD_STAT_ADDR   = 32'hffe00118;
  localparam int          ERD_GATE_BIT    = 31;
  localparam int          ERD_EN_BIT      = 0;
  localparam int          ERD_EMPTY_BIT   = 0;
  localparam int          ERD_FULL_BIT    = 1;
  // Descriptor and status layout
  localparam int          ERD_SLOT_SHIFT  = 3;
  localparam logic [31:0] ERD_PTR_OFF     = 32'h0;
  localparam logic [31:0] ERD_CTL_OFF     = 32'h4;
  localparam logic [31:0] ERD_FLAGS_OFF   = 32'h0;
  localparam logic [31:0] ERD_HASH_OFF    = 32'h4;
  localparam int          ERD_LEN_W       = 11;
  localparam int          ERD_IRQ_BIT     = 31;
  localparam int          ERD_NODESC_BIT  = 29;
  localparam int          ERD_HASH_W      = 9;
  localparam int          ERD_SRC_LSB     = 0;
  localparam int          ERD_DST_LSB     = 16;
  localparam logic [3:0]  ERD_BE_BYTE     = 4'h1;
  localparam logic [3:0]  ERD_BE_WORD     = 4'hf;
  localparam logic [31:0] ERD_RING_ALIGN  = 32'h3;
  localparam logic [31:0] ERD_ST_ALIGN    = 32'h7;
  // Host APB map
  localparam logic [11:0] ERH_CADDR_OFF   = 12'h000;
  localparam logic [11:0] ERH_CWDATA_OFF  = 12'h004;
  localparam logic [11:0] ERH_CCTRL_OFF   = 12'h008;
  localparam logic [11:0] ERH_CRDATA_OFF  = 12'h00c;
  localparam logic [11:0] ERH_WIN_OFF     = 12'h100;
  localparam int          ERH_BUSY_BIT    = 0;
  localparam int          ERH_ERR_BIT     = 1;
  localparam int          ERH_REFUSE_BIT  = 2;
  localparam int          ERH_DIR_BIT     = 0;

  typedef enum logic [3:0] {
    ERD_IDLE, ERD_RD_PTR, ERD_RD_CTL, ERD_DATA, ERD_WR_BYTE,
    ERD_WR_FLAGS, ERD_WR_HASH, ERD_ADVANCE, ERD_DROP
  } erd_state_t;
endpackage

/* File: include/erd_if.sv */
`timescale 1ns/100ps
interface erd_if;
  logic        reg_req;
  logic        reg_we;
  logic [31:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_ack;
  logic        reg_err;
  logic        mem_req;
  logic        mem_we;
  logic [31:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [3:0]  mem_be;
  logic [31:0] mem_rdata;
  logic        mem_ack;

  modport dev (input reg_req, reg_we, reg_addr, reg_wdata, mem_rdata, mem_ack,
               output reg_rdata, reg_ack, reg_err, mem_req, mem_we, mem_addr,
               mem_wdata, mem_be);
  modport host (output reg_req, reg_we, reg_addr, reg_wdata, mem_rdata, mem_ack,
                input reg_rdata, reg_ack, reg_err, mem_req, mem_we, mem_addr,
                mem_wdata, mem_be);
endinterface

/* File: src/erd_mem.sv */
`timescale 1ns/100ps
module erd_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_we,
  input  wire logic [3:0]    i_be,
  input  wire logic [AW-1:0] i_idx,
  input  wire logic [31:0]   i_wdata,
  output logic      [31:0]   o_rdata
);
  logic [31:0] mem_reg [DEPTH];

  // Byte-lane write, cleared on reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (i_we) begin
      for (int b = 0; b < 4; b++) begin
        if (i_be[b]) begin
          mem_reg[i_idx][b*8 +: 8] <= i_wdata[b*8 +: 8];
        end
      end
    end
  end

  assign o_rdata = mem_reg[i_idx];
endmodule

/* File: src/erd_host.sv */
`timescale 1ns/100ps
module erd_host #(
  parameter int MEM_DEPTH = 64,
  parameter int MEM_AW    = $clog2(MEM_DEPTH)
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  erd_if.host              LINK
);
  import erd_pkg::*;

  logic [31:0] caddr_reg, cwdata_reg, crdata_reg, prdata_reg;
  logic        dir_reg, busy_reg, err_reg, refuse_reg, shadow_en_reg;
  logic        done_reg, perr_reg, mack_reg;
  logic [31:0] mrdata_reg, mem_rd, rd_val;
  logic        dma_now, in_win, mapped, apb_acc, apb_fin, apb_mem_wr, bad_cfg;
  logic [MEM_AW-1:0] mem_idx;

  // DMA owns the memory while it requests; APB waits
  assign dma_now    = LINK.mem_req & ~mack_reg;
  assign in_win     = (I_PADDR >= ERH_WIN_OFF);
  assign apb_acc    = I_PSEL & I_PENABLE;
  assign O_PREADY   = done_reg & ~(in_win & I_PWRITE & dma_now);
  assign apb_fin    = apb_acc & O_PREADY;
  assign apb_mem_wr = apb_fin & I_PWRITE & in_win;
  assign mem_idx    = dma_now ? LINK.mem_addr[MEM_AW+1:2]
                              : MEM_AW'((I_PADDR - ERH_WIN_OFF) >> 2);

  erd_mem #(.DEPTH(MEM_DEPTH), .AW(MEM_AW)) u_mem (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_we    (dma_now ? LINK.mem_we : apb_mem_wr),
    .i_be    (dma_now ? LINK.mem_be : ERD_BE_WORD),
    .i_idx   (mem_idx),
    .i_wdata (dma_now ? LINK.mem_wdata : I_PWDATA),
    .o_rdata (mem_rd)
  );

  // Memory answer one cycle after the request
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mack_reg   <= 1'b0;
      mrdata_reg <= '0;
    end else begin
      mack_reg <= dma_now;
      if (dma_now) begin
        mrdata_reg <= mem_rd;
      end
    end
  end

  // APB read decode
  always_comb begin
    mapped = 1'b1;
    rd_val = '0;
    if (in_win) begin
      mapped = (32'(I_PADDR - ERH_WIN_OFF) >> 2) < MEM_DEPTH;
      rd_val = mem_rd;
    end else begin
      case (I_PADDR)
        ERH_CADDR_OFF:  rd_val = caddr_reg;
        ERH_CWDATA_OFF: rd_val = cwdata_reg;
        ERH_CRDATA_OFF: rd_val = crdata_reg;
        ERH_CCTRL_OFF: begin
          rd_val[ERH_BUSY_BIT]   = busy_reg;
          rd_val[ERH_ERR_BIT]    = err_reg;
          rd_val[ERH_REFUSE_BIT] = refuse_reg;
        end
        default: mapped = 1'b0;
      endcase
    end
  end

  // APB access phase: sample in first cycle, answer in the next
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      done_reg   <= 1'b0;
      prdata_reg <= '0;
      perr_reg   <= 1'b0;
    end else if (apb_fin) begin
      done_reg <= 1'b0;
    end else if (apb_acc & ~done_reg & ~(in_win & dma_now)) begin
      done_reg   <= 1'b1;
      prdata_reg <= I_PWRITE ? '0 : rd_val;
      perr_reg   <= ~mapped;
    end
  end

  assign O_PRDATA  = prdata_reg;
  assign O_PSLVERR = perr_reg;

  // Misaligned bases or base and count writes while enabled are not forwarded
  assign bad_cfg = dir_reg & (((caddr_reg == ERD_RING_ADDR)
                 & |(cwdata_reg & ERD_RING_ALIGN))
                 | ((caddr_reg == ERD_STBASE_ADDR)
                 & |(cwdata_reg & ERD_ST_ALIGN))
                 | (shadow_en_reg & ((caddr_reg == ERD_RING_ADDR)
                 | (caddr_reg == ERD_STBASE_ADDR)
                 | (caddr_reg == ERD_COUNT_ADDR))));

  // Command registers and device access engine
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      caddr_reg     <= '0;
      cwdata_reg    <= '0;
      crdata_reg    <= '0;
      dir_reg       <= 1'b0;
      busy_reg      <= 1'b0;
      err_reg       <= 1'b0;
      refuse_reg    <= 1'b0;
      shadow_en_reg <= 1'b0;
    end else begin
      if (busy_reg & LINK.reg_ack) begin
        busy_reg   <= 1'b0;
        crdata_reg <= LINK.reg_rdata;
        err_reg    <= LINK.reg_err;
        if (dir_reg & ~LINK.reg_err & (caddr_reg == ERD_CTRL_ADDR)) begin
          shadow_en_reg <= cwdata_reg[ERD_EN_BIT];
        end
      end
      if (apb_fin & I_PWRITE & ~busy_reg) begin
        case (I_PADDR)
          ERH_CADDR_OFF:  caddr_reg <= I_PWDATA;
          ERH_CWDATA_OFF: cwdata_reg <= I_PWDATA;
          ERH_CCTRL_OFF:  dir_reg <= I_PWDATA[ERH_DIR_BIT];
          default:        dir_reg <= dir_reg;
        endcase
        if (I_PADDR == ERH_CCTRL_OFF) begin
          busy_reg   <= 1'b1;
          refuse_reg <= 1'b0;
          err_reg    <= 1'b0;
        end
      end
      if (busy_reg & ~LINK.reg_ack & bad_cfg) begin
        busy_reg   <= 1'b0;
        refuse_reg <= 1'b1;
      end
    end
  end

  assign LINK.reg_req   = busy_reg & ~bad_cfg;
  assign LINK.reg_we    = dir_reg;
  assign LINK.reg_addr  = caddr_reg;
  assign LINK.reg_wdata = cwdata_reg;
  assign LINK.mem_ack   = mack_reg;
  assign LINK.mem_rdata = mrdata_reg;
endmodule

/* File: verif/erd_sva.sv */
`timescale 1ns/100ps
module erd_sva
  import erd_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        reg_req,
  input wire logic        reg_we,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_ack,
  input wire logic        reg_err,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0]  mem_be,
  input wire logic        mem_ack
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic        gate_reg;
  logic        ph_reg;
  logic [31:0] rd_reg;
  logic [31:0] fl_reg;
  wire         rtk = reg_req && !reg_ack;
  wire         gad = reg_addr == ERD_GATE_ADDR;
  wire         mtk = mem_req && !mem_ack;
  wire         wtk = mtk && mem_we && mem_be == ERD_BE_WORD;
  // Shadow of the gate bit as written over the link
  always_ff @(posedge I_CLK) begin
    if (I_RST) gate_reg <= 1'b0;
    else if (rtk && reg_we && gad) gate_reg <= reg_wdata[ERD_GATE_BIT];
  end
  // Pointer or control phase of descriptor reads
  always_ff @(posedge I_CLK) begin
    if (I_RST) ph_reg <= 1'b0;
    else if (mtk && !mem_we) ph_reg <= !ph_reg;
  end
  // Last descriptor read and last flags write addresses
  always_ff @(posedge I_CLK) begin
    if (mtk && !mem_we) rd_reg <= mem_addr;
    if (wtk && !mem_addr[2]) fl_reg <= mem_addr;
  end
  gate_block_a: assert property (rtk && gate_reg && !gad |=> reg_ack && reg_err)
    else $error("gated access not refused");
  gate_open_a: assert property (rtk && gad |=> reg_ack && !reg_err)
    else $error("gate register access refused");
  err_ack_a: assert property (reg_err |-> reg_ack)
    else $error("error without acknowledge");
  mem_hold_a: assert property (mtk |=> mem_ack && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request not held to its answer");
  byte_lane_a: assert property (mtk && mem_we && mem_be != ERD_BE_WORD |->
    $onehot(mem_be) && mem_wdata == {4{mem_wdata[7:0]}}) else $error("bad byte lane");
  ctl_after_a: assert property (mtk && !mem_we && ph_reg |-> mem_addr == rd_reg + 32'h4)
    else $error("control word not at pointer plus four");
  hash_after_a: assert property (wtk && mem_addr[2] |-> mem_addr == fl_reg + 32'h4)
    else $error("hash word not at flags plus four");
  hash_zero_a: assert property (wtk && mem_addr[2] |->
    mem_wdata[15:9] == 7'h0 && mem_wdata[31:25] == 7'h0) else $error("hash spare bits set");
endmodule

/* File: verif/tb_eth_rx_descriptor_dma.sv */
`timescale 1ns/100ps
module tb_eth_rx_descriptor_dma;
  import erd_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        rv = 1'b0, rl = 1'b0, hv = 1'b0, prdy, rrdy, ev, ovr, emp, full, perr, re;
  logic [11:0] pa = 12'h0;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [8:0]  sh = 9'h0, dh = 9'h0;
  logic [7:0]  rdat = 8'h0;
  logic [7:0]  fr [16];
  logic [1:0]  off [4];
  logic        irq [4];
  int          seed = 32'h56f04d68;
  int          n_fail = 0, n_checks = 0, cyc = 0, nev = 0, nov = 0;
  erd_if lnk ();
  erd_host erd_host_i (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
    .LINK(lnk));
  erd_dev erd_dev_i (.I_CLK(clk), .I_RST(rst), .LINK(lnk), .I_RX_VALID(rv), .I_RX_DATA(rdat),
    .I_RX_LAST(rl), .O_RX_READY(rrdy), .I_HASH_VALID(hv), .I_SRC_HASH(sh), .I_DST_HASH(dh),
    .O_RX_COMPLETE_EVENT(ev), .O_OVERRUN(ovr), .O_RING_EMPTY(emp), .O_RING_FULL(full));
  erd_sva erd_sva_i (.I_CLK(clk), .I_RST(rst), .reg_req(lnk.reg_req), .reg_we(lnk.reg_we),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_ack(lnk.reg_ack),
    .reg_err(lnk.reg_err), .mem_req(lnk.mem_req), .mem_we(lnk.mem_we), .mem_addr(lnk.mem_addr),
    .mem_wdata(lnk.mem_wdata), .mem_be(lnk.mem_be), .mem_ack(lnk.mem_ack));
  initial forever #12.5 clk = ~clk;
  // Cycle ceiling and pulse counters
  always @(posedge clk) begin
    cyc++;
    if (ev === 1'b1) nev++;
    if (ovr === 1'b1) nov++;
    if (cyc == 30000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done();
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Flags word of fragment j of an n byte frame, buffers of four bytes
  function automatic logic [31:0] flg(input int n, input int j);
    int l;
    l = n - 4 * j > 4 ? 4 : n - 4 * j;
    return 32'(l - 1) | (32'(n > 12 && j == 2) << ERD_NODESC_BIT);
  endfunction
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    re = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic mem(input logic w, input int i, input logic [31:0] d);
    apb(w, ERH_WIN_OFF + 12'(4 * i), d);
  endtask
  // Device register access through the host, status checked, read data left in rd
  task automatic dev(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] st);
    apb(1'b1, ERH_CADDR_OFF, a);
    apb(1'b1, ERH_CWDATA_OFF, d);
    apb(1'b1, ERH_CCTRL_OFF, {31'h0, w});
    do apb(1'b0, ERH_CCTRL_OFF, 32'h0); while (rd[ERH_BUSY_BIT] !== 1'b0);
    chk(rd, st);
    apb(1'b0, ERH_CRDATA_OFF, 32'h0);
  endtask
  // Hash strobe, then n random bytes of one frame
  task automatic send(input int n);
    @(posedge clk);
    hv <= 1'b1;
    sh <= 9'($random(seed));
    dh <= 9'($random(seed));
    @(posedge clk);
    hv <= 1'b0;
    for (int i = 0; i < n; i++) begin
      fr[i] = 8'($random(seed));
      rv <= 1'b1;
      rdat <= fr[i];
      rl <= i == n - 1;
      do @(posedge clk); while (rrdy !== 1'b1);
    end
    rv <= 1'b0;
    rl <= 1'b0;
    rdat <= ~rdat;
  endtask
  initial begin
    int n, f, k, hw, nevx, novx;
    logic [31:0] a;
    hw = 0;
    nevx = 0;
    novx = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    dev(1'b0, ERD_GATE_ADDR, 32'h0, 32'h0);
    chk(rd, 32'h0);
    dev(1'b1, ERD_GATE_ADDR, 32'h80000000, 32'h0);
    dev(1'b0, ERD_RING_ADDR, 32'h0, 32'h2);
    dev(1'b1, ERD_SWIDX_ADDR, 32'h0, 32'h2);
    dev(1'b0, ERD_GATE_ADDR, 32'h0, 32'h0);
    chk(rd, 32'h80000000);
    dev(1'b1, ERD_GATE_ADDR, 32'h0, 32'h0);
    dev(1'b0, 32'hffe00200, 32'h0, 32'h2);
    chk(re, 32'h0);
    // Host's own error answer: unmapped register, window past the memory
    apb(1'b0, 12'h010, 32'h0);
    chk(re, 32'h1);
    apb(1'b0, 12'h200, 32'h0);
    chk(re, 32'h1);
    // Four descriptors, four byte buffers at random byte offsets
    for (int i = 0; i < 4; i++) begin
      off[i] = 2'($random(seed));
      irq[i] = 1'($random(seed));
      mem(1'b1, 2 * i, 32'h80 + 8 * i + off[i]);
      mem(1'b1, 2 * i + 1, {irq[i], 20'h0, 11'h3});
    end
    dev(1'b1, ERD_RING_ADDR, 32'h2, 32'h4);
    dev(1'b1, ERD_STBASE_ADDR, 32'h44, 32'h4);
    dev(1'b1, ERD_STBASE_ADDR, 32'h40, 32'h0);
    dev(1'b1, ERD_COUNT_ADDR, 32'h3, 32'h0);
    dev(1'b1, ERD_CTRL_ADDR, 32'h1, 32'h0);
    dev(1'b1, ERD_COUNT_ADDR, 32'h7, 32'h4);
    for (int i = 0; i < 10; i++) begin
      n = i == 0 ? 13 : i == 1 ? 4 : 1 + $unsigned($random(seed)) % 12;
      f = n > 12 ? 3 : (n + 3) / 4;
      send(n);
      do dev(1'b0, ERD_HWIDX_ADDR, 32'h0, 32'h0); while (rd !== 32'((hw + f) % 4));
      for (int j = 0; j < f; j++) begin
        k = (hw + j) % 4;
        nevx += irq[k];
        mem(1'b0, 16 + 2 * k, 32'h0);
        chk(rd, flg(n, j));
        mem(1'b0, 17 + 2 * k, 32'h0);
        chk(rd, {7'h0, dh, 7'h0, sh});
        for (int b = 0; b < 5; b++) begin
          a = 32'h80 + 8 * k + off[k] + b;
          mem(1'b0, a[7:2], 32'h0);
          if (b == 4) chk(rd[8 * a[1:0] +: 8], 32'h0);
          else if (4 * j + b < n) chk(rd[8 * a[1:0] +: 8], fr[4 * j + b]);
        end
      end
      chk(nev, nevx);
      chk({emp, full}, {1'b0, f == 3});
      dev(1'b0, ERD_STAT_ADDR, 32'h0, 32'h0);
      chk(rd, {30'h0, f == 3, 1'b0});
      // Frame against a full ring is dropped untouched
      if (f == 3) begin
        send(2);
        novx++;
        dev(1'b0, ERD_HWIDX_ADDR, 32'h0, 32'h0);
        chk(rd, (hw + f) % 4);
        chk(nov, novx);
      end
      hw = (hw + f) % 4;
      dev(1'b1, ERD_SWIDX_ADDR, hw, 32'h0);
      chk(emp, 32'h1);
    end
    test_done();
  end
endmodule
